// >>> pkg/bbd_pkg.sv
// bbd_pkg: opcodes, decode classes, register map and timing of the
// bit-manipulation and relative-branch execution unit.
// assumes an 8-bit core with a 16-bit program counter.
package bbd_pkg;
  // opcodes with a fixed byte
  localparam logic [7:0] OP_CAND = 8'h8b, OP_CXOR = 8'hab, OP_COR = 8'h6b;
  localparam logic [7:0] OP_LDC = 8'hcb, OP_NOT = 8'h4b, OP_STC = 8'heb;
  localparam logic [7:0] OP_BITDP = 8'h0c, OP_BITAB = 8'h1c;
  localparam logic [7:0] OP_ACLR = 8'h2b, OP_ASET = 8'h0b;
  localparam logic [7:0] OP_CARRY_FORCE_LOW = 8'h20, OP_G_FLAG_FORCE_LOW = 8'h40, OP_OVERFLOW_FORCE_LOW = 8'h80;
  localparam logic [7:0] OP_CARRY_FORCE_HIGH = 8'ha0, OP_G_FLAG_FORCE_HIGH = 8'hc0;
  localparam logic [7:0] OP_TCLR = 8'h5c, OP_TSET = 8'h3c, OP_BRA = 8'h2f;
  // low nibble of the x/y families and of the flag branches
  localparam logic [3:0] LO_MBIT = 4'h1, LO_ABR = 4'h2, LO_MBR = 4'h3;
  localparam logic [3:0] LO_FBR = 4'h0;
  // opcode fields: bit number, clear/low variant
  localparam int OPB_HI = 7, OPB_LO = 5, OPB_CLR = 4;
  // high operand byte of a bit operand: bit[7:5], inverted[4], addr[3:0]
  localparam int MB_HI = 7, MB_LO = 5, MB_INV = 4;
  localparam int ABIT_HI = 2;
  // status word NVGBHIZC
  localparam int PSW_N = 7, PSW_V = 6, PSW_G = 5, PSW_Z = 1, PSW_C = 0;
  localparam logic [7:0] PSW_CMASK = 8'h01;
  localparam logic [6:0] DP_HI = 7'h00;
  // lengths and cycle counts
  localparam logic [1:0] LEN_1 = 2'h1, LEN_2 = 2'h2, LEN_3 = 2'h3;
  localparam logic [2:0] CY_CAND = 3'h4, CY_BITDP = 3'h4, CY_BITAB = 3'h5;
  localparam logic [2:0] CY_MBIT = 3'h4, CY_ABIT = 3'h2, CY_FLAG = 3'h2;
  localparam logic [2:0] CY_CXOR = 3'h5, CY_LDC = 3'h4, CY_NOT = 3'h5;
  localparam logic [2:0] CY_COR = 3'h5, CY_STC = 3'h6, CY_TST = 3'h6;
  localparam logic [2:0] CY_ABR = 3'h4, CY_ABR_TK = 3'h6;
  localparam logic [2:0] CY_MBR = 3'h5, CY_MBR_TK = 3'h7;
  localparam logic [2:0] CY_FBR = 3'h2, CY_FBR_TK = 3'h4, CY_BRA = 3'h4;
  // run counter: memory data captured, memory written
  localparam logic [2:0] CNT_CAP = 3'h1, CNT_WR = 3'h2;
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00, REG_STAT = 8'h04, REG_INSN = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0c, REG_PSW = 8'h10, REG_PC = 8'h14;
  localparam int CTRL_GO = 0, CTRL_CLR = 1;
  localparam int SB_BUSY = 0, SB_DONE = 1, SB_ILL = 2, SB_CYC_LO = 8, SB_CYC_HI = 10;
  localparam logic [1:0] AXI_OKAY = 2'b00, AXI_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    CL_ILL = 4'b0000, CL_CAND = 4'b0001, CL_COR = 4'b0010, CL_CXOR = 4'b0011,
    CL_LDC = 4'b0100, CL_STC = 4'b0101, CL_NOT = 4'b0110, CL_BIT = 4'b0111,
    CL_MBIT = 4'b1000, CL_ABIT = 4'b1001, CL_FLAG = 4'b1010, CL_TST = 4'b1011,
    CL_ABR = 4'b1100, CL_MBR = 4'b1101, CL_FBR = 4'b1110, CL_BRA = 4'b1111
  } bbd_cls_e;
  typedef enum logic [1:0] {
    AM_NONE = 2'b00, AM_DP = 2'b01, AM_ABS = 2'b10, AM_MB = 2'b11
  } bbd_am_e;
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} bbd_st_e;
  typedef struct packed {
    bbd_cls_e   cls;
    logic [1:0] len;
    logic [2:0] cyc;
    logic [2:0] ctk;
    bbd_am_e    am;
    logic       wr;
  } bbd_dec_s;
  localparam bbd_dec_s DEC_ILL = '{CL_ILL, LEN_1, CY_FLAG, CY_FLAG, AM_NONE, 1'b0};
endpackage : bbd_pkg

// >>> rtl/bbd_decode.sv
// bbd_decode: opcode byte to class, length, cycle counts and operand form.
// assumes the opcode stays stable while the instruction runs.
`timescale 1ns/100ps
module bbd_decode
  import bbd_pkg::*;
(
  // opcode
  input  wire logic [7:0] op,
  // decoded instruction
  output bbd_dec_s        dec
);
  always_comb
  begin
    dec = DEC_ILL;
    if (op[3:0] == LO_MBIT)
      dec = '{CL_MBIT, LEN_2, CY_MBIT, CY_MBIT, AM_DP, 1'b1};
    else if (op[3:0] == LO_ABR)
      dec = '{CL_ABR, LEN_2, CY_ABR, CY_ABR_TK, AM_NONE, 1'b0};
    else if (op[3:0] == LO_MBR)
      dec = '{CL_MBR, LEN_3, CY_MBR, CY_MBR_TK, AM_DP, 1'b0};
    else if (op[3:0] == LO_FBR && op[OPB_CLR])
      dec = '{CL_FBR, LEN_2, CY_FBR, CY_FBR_TK, AM_NONE, 1'b0};
    else
    begin
      unique case (op)
        OP_CAND:  dec = '{CL_CAND, LEN_3, CY_CAND, CY_CAND, AM_MB, 1'b0};
        OP_BITDP: dec = '{CL_BIT, LEN_2, CY_BITDP, CY_BITDP, AM_DP, 1'b0};
        OP_BITAB: dec = '{CL_BIT, LEN_3, CY_BITAB, CY_BITAB, AM_ABS, 1'b0};
        OP_ACLR, OP_ASET:
          dec = '{CL_ABIT, LEN_2, CY_ABIT, CY_ABIT, AM_NONE, 1'b0};
        OP_CARRY_FORCE_LOW, OP_G_FLAG_FORCE_LOW, OP_OVERFLOW_FORCE_LOW, OP_CARRY_FORCE_HIGH, OP_G_FLAG_FORCE_HIGH:
          dec = '{CL_FLAG, LEN_1, CY_FLAG, CY_FLAG, AM_NONE, 1'b0};
        OP_CXOR:  dec = '{CL_CXOR, LEN_3, CY_CXOR, CY_CXOR, AM_MB, 1'b0};
        OP_LDC:   dec = '{CL_LDC, LEN_3, CY_LDC, CY_LDC, AM_MB, 1'b0};
        OP_NOT:   dec = '{CL_NOT, LEN_3, CY_NOT, CY_NOT, AM_MB, 1'b1};
        OP_COR:   dec = '{CL_COR, LEN_3, CY_COR, CY_COR, AM_MB, 1'b0};
        OP_STC:   dec = '{CL_STC, LEN_3, CY_STC, CY_STC, AM_MB, 1'b1};
        OP_TCLR, OP_TSET:
          dec = '{CL_TST, LEN_3, CY_TST, CY_TST, AM_ABS, 1'b1};
        OP_BRA:   dec = '{CL_BRA, LEN_2, CY_BRA, CY_BRA, AM_NONE, 1'b0};
        default:  dec = DEC_ILL;
      endcase
    end
  end
endmodule : bbd_decode

// >>> rtl/bbd_bitalu.sv
// bbd_bitalu: flag, accumulator and memory-byte results of one instruction.
// assumes mdat already holds the addressed memory byte when it is used.
`timescale 1ns/100ps
module bbd_bitalu
  import bbd_pkg::*;
(
  // instruction
  input  wire bbd_cls_e   cls,
  input  wire logic [7:0] op,
  input  wire logic [7:0] b1,
  input  wire logic [7:0] b2,
  // core state
  input  wire logic [7:0] acc,
  input  wire logic [7:0] psw,
  input  wire logic [7:0] mdat,
  // results
  output logic [7:0]      n_psw,
  output logic [7:0]      n_acc,
  output logic [7:0]      n_mem,
  output logic            taken
);
  always_comb
  begin
    logic [2:0] bi;
    logic       mb;
    logic [7:0] dif;
    logic [3:0] fv;
    bi = b2[MB_HI:MB_LO];
    if (cls == CL_ABIT)
      bi = b1[ABIT_HI:0];
    else if (cls inside {CL_MBIT, CL_ABR, CL_MBR})
      bi = op[OPB_HI:OPB_LO];
    // inverted forms share the opcode; the operand flag picks them
    mb = mdat[bi] ^ b2[MB_INV];
    dif = acc - mdat;
    fv = {psw[PSW_Z], psw[PSW_C], psw[PSW_V], psw[PSW_N]};
    n_psw = psw;
    n_acc = acc;
    n_mem = mdat;
    taken = 1'b0;
    unique case (cls)
      CL_CAND: n_psw[PSW_C] = psw[PSW_C] & mb;
      CL_CXOR: n_psw[PSW_C] = psw[PSW_C] ^ mb;
      CL_LDC:  n_psw[PSW_C] = mb;
      CL_COR:  n_psw[PSW_C] = psw[PSW_C] | mb;
      CL_NOT:  n_mem[bi] = ~mdat[bi];
      CL_STC:  n_mem[bi] = psw[PSW_C];
      CL_MBIT: n_mem[bi] = ~op[OPB_CLR];
      CL_ABIT: n_acc[bi] = (op == OP_ASET);
      CL_BIT:
      begin
        n_psw[PSW_Z] = ~|(acc & mdat);
        n_psw[PSW_N] = mdat[PSW_N];
        n_psw[PSW_V] = mdat[PSW_V];
      end
      CL_FLAG:
      begin
        if (op == OP_CARRY_FORCE_LOW || op == OP_CARRY_FORCE_HIGH)
          n_psw[PSW_C] = op[OPB_HI];
        if (op == OP_G_FLAG_FORCE_LOW || op == OP_G_FLAG_FORCE_HIGH)
          n_psw[PSW_G] = op[OPB_HI];
        if (op == OP_OVERFLOW_FORCE_LOW)
          n_psw[PSW_V] = 1'b0;
      end
      CL_TST:
      begin
        n_psw[PSW_N] = dif[PSW_N];
        n_psw[PSW_Z] = (dif == 8'h00);
        n_mem = (op == OP_TSET) ? (mdat | acc) : (mdat & ~acc);
      end
      CL_ABR:  taken = acc[bi] ^ op[OPB_CLR];
      CL_MBR:  taken = mdat[bi] ^ op[OPB_CLR];
      CL_FBR:  taken = (fv[op[6:5]] == op[OPB_HI]);
      CL_BRA:  taken = 1'b1;
      CL_ILL:  taken = 1'b0;
    endcase
  end
endmodule : bbd_bitalu

// >>> rtl/bbd_core.sv
// bbd_core: bit-manipulation and relative-branch execution unit behind an
// axi4-lite slave. software loads the instruction bytes, acc, psw and pc,
// then starts it; the unit runs it with the documented cycle count.
// assumes a data memory that returns mem_rdata one cycle after mem_rd.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module bbd_core
  import bbd_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // data memory
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata
);
  typedef struct packed {
    bbd_st_e     st;
    logic [2:0]  cnt;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  acc;
    logic [7:0]  psw;
    logic [15:0] pc;
    logic [7:0]  mdat;
    logic        done;
    logic        ill;
    logic [2:0]  lastc;
    logic [15:0] maddr;
    logic        mrd;
    logic        mwr;
    logic [7:0]  mwd;
    logic        aw_h;
    logic        w_h;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        awrdy;
    logic        wrdy;
    logic        bvld;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvld;
    logic [31:0] rd;
    logic [1:0]  rresp;
  } bbd_core_s;

  localparam bbd_core_s S_RST = '0;

  bbd_core_s   s;
  bbd_core_s   next_s;
  bbd_dec_s    dec;
  logic [7:0]  alu_psw;
  logic [7:0]  alu_acc;
  logic [7:0]  alu_mem;
  logic        alu_taken;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        start;
  logic        fin;
  logic [2:0]  ctot;
  logic [7:0]  rel;
  logic [15:0] ea;
  logic [15:0] pc_next;

  bbd_decode u_dec (
    .op  (s.op),
    .dec (dec)
  );

  bbd_bitalu u_alu (
    .cls   (dec.cls),
    .op    (s.op),
    .b1    (s.b1),
    .b2    (s.b2),
    .acc   (s.acc),
    .psw   (s.psw),
    .mdat  (s.mdat),
    .n_psw (alu_psw),
    .n_acc (alu_acc),
    .n_mem (alu_mem),
    .taken (alu_taken)
  );

  for (genvar i = 0; i < 4; i++)
  begin : g_mask
    assign wmask[8*i +: 8] = {8{s.ws[i]}};
  end

  function automatic logic [31:0] rdmux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      REG_STAT:
      begin
        r[SB_BUSY] = (s.st == ST_RUN);
        r[SB_DONE] = s.done;
        r[SB_ILL] = s.ill;
        r[SB_CYC_HI:SB_CYC_LO] = s.lastc;
      end
      REG_INSN: r = {8'h00, s.b2, s.b1, s.op};
      REG_ACC:  r = {24'h0, s.acc};
      REG_PSW:  r = {24'h0, s.psw};
      REG_PC:   r = {16'h0, s.pc};
      default:  r = 32'h0;
    endcase
    return r;
  endfunction : rdmux

  // operand address, cycle total and branch target
  always_comb
  begin
    unique case (dec.am)
      AM_NONE: ea = 16'h0;
      AM_DP:   ea = {DP_HI, s.psw[PSW_G], s.b1};
      AM_ABS:  ea = {s.b2, s.b1};
      AM_MB:   ea = {4'h0, s.b2[3:0], s.b1};
    endcase
    ctot = alu_taken ? dec.ctk : dec.cyc;
    fin = (s.st == ST_RUN) && (s.cnt == ctot - 3'h1);
    rel = (dec.len == LEN_3) ? s.b2 : s.b1;
    pc_next = s.pc + {14'h0, dec.len};
    if (alu_taken)
      pc_next = pc_next + {{8{rel[7]}}, rel};
    wval = (s.wd & wmask) | (rdmux(s.awa) & ~wmask);
  end

  always_comb
  begin
    next_s = s;
    start = 1'b0;
    next_s.mrd = 1'b0;
    next_s.mwr = 1'b0;
    if (s_axi_awvalid && s.awrdy)
    begin
      next_s.aw_h = 1'b1;
      next_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wrdy)
    begin
      next_s.w_h = 1'b1;
      next_s.wd = s_axi_wdata;
      next_s.ws = s_axi_wstrb;
    end
    if (s.bvld && s_axi_bready)
      next_s.bvld = 1'b0;
    // writes while running are answered; all but the clear bit of REG_CTRL are ignored, so operands stay put
    if (s.aw_h && s.w_h && !s.bvld)
    begin
      next_s.aw_h = 1'b0;
      next_s.w_h = 1'b0;
      next_s.bvld = 1'b1;
      next_s.bresp = AXI_OKAY;
      unique case (s.awa)
        REG_CTRL:
        begin
          if (s.ws[0] && s.wd[CTRL_CLR])
          begin
            next_s.done = 1'b0;
            next_s.ill = 1'b0;
          end
          if (s.ws[0] && s.wd[CTRL_GO] && s.st == ST_IDLE)
          begin
            if (dec.cls == CL_ILL)
              next_s.ill = 1'b1;
            else
            begin
              start = 1'b1;
              next_s.st = ST_RUN;
              next_s.cnt = 3'h0;
              next_s.mrd = (dec.am != AM_NONE);
              next_s.maddr = ea;
            end
          end
        end
        REG_STAT: next_s.bresp = AXI_OKAY;
        REG_INSN:
        begin
          if (s.st == ST_IDLE)
            {next_s.b2, next_s.b1, next_s.op} = wval[23:0];
        end
        REG_ACC:
        begin
          if (s.st == ST_IDLE)
            next_s.acc = wval[7:0];
        end
        REG_PSW:
        begin
          if (s.st == ST_IDLE)
            next_s.psw = wval[7:0];
        end
        REG_PC:
        begin
          if (s.st == ST_IDLE)
            next_s.pc = wval[15:0];
        end
        default: next_s.bresp = AXI_SLVERR;
      endcase
    end
    if (s.rvld && s_axi_rready)
      next_s.rvld = 1'b0;
    if (s_axi_arvalid && s.arrdy)
    begin
      next_s.rvld = 1'b1;
      next_s.rd = rdmux(s_axi_araddr);
      next_s.rresp = (s_axi_araddr inside {REG_CTRL, REG_STAT, REG_INSN, REG_ACC,
                      REG_PSW, REG_PC}) ? AXI_OKAY : AXI_SLVERR;
    end
    next_s.awrdy = !next_s.aw_h && !next_s.bvld;
    next_s.wrdy = !next_s.w_h && !next_s.bvld;
    next_s.arrdy = !next_s.rvld;
    // execution; the finish comes after the bus so done set beats clear
    if (s.st == ST_RUN)
    begin
      next_s.cnt = s.cnt + 3'h1;
      if (s.cnt == CNT_CAP)
        next_s.mdat = mem_rdata;
      if (s.cnt == CNT_WR && dec.wr)
      begin
        next_s.mwr = 1'b1;
        next_s.mwd = alu_mem;
      end
      if (fin)
      begin
        next_s.st = ST_IDLE;
        next_s.psw = alu_psw;
        next_s.acc = alu_acc;
        next_s.pc = pc_next;
        next_s.done = 1'b1;
        next_s.lastc = ctot;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s <= S_RST;
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awrdy;
  assign s_axi_wready = s.wrdy;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvld;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rdata = s.rd;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvld;
  assign mem_addr = s.maddr;
  assign mem_rd = s.mrd;
  assign mem_wr = s.mwr;
  assign mem_wdata = s.mwd;

  // checks
  logic        xor_exp;
  logic [15:0] bra_tgt;
  assign xor_exp = s.psw[PSW_C] ^ s.mdat[s.b2[MB_HI:MB_LO]] ^ s.b2[MB_INV];
  assign bra_tgt = s.pc + {14'h0, LEN_2} + {{8{s.b1[7]}}, s.b1};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_go(logic [7:0] o);
    start && s.op == o;
  endsequence
  sequence seq_run4;
    (s.st == ST_RUN) [*4];
  endsequence

  AST_CAND_TIME: assert property (seq_go(OP_CAND) |=> seq_run4 ##1
    (s.st == ST_IDLE && s.done && s.pc == $past(s.pc, 5) + 16'h0003))
    else $error("carry and-bit did not take four cycles");
  AST_BITAB_TIME: assert property (seq_go(OP_BITAB) |=> (s.st == ST_RUN) [*5] ##1
    (s.st == ST_IDLE && s.pc == $past(s.pc, 6) + 16'h0003))
    else $error("absolute bit test did not take five cycles");
  AST_MBIT_WRITE: assert property ((start && dec.cls == CL_MBIT) |=> ##2 !mem_wr ##1
    (mem_wr && mem_wdata[s.op[OPB_HI:OPB_LO]] == !s.op[OPB_CLR]) ##1
    (s.st == ST_IDLE && s.psw == $past(s.psw, 5)))
    else $error("direct page bit force wrong or flags changed");
  AST_ABIT_TIME: assert property (seq_go(OP_ASET) |=> (s.st == ST_RUN) [*2] ##1
    (s.st == ST_IDLE && s.acc[s.b1[ABIT_HI:0]]))
    else $error("accumulator bit set wrong");
  AST_CXOR_CARRY: assert property ((fin && dec.cls == CL_CXOR) |=>
    (s.psw[PSW_C] == $past(xor_exp) &&
     (s.psw | PSW_CMASK) == ($past(s.psw) | PSW_CMASK)))
    else $error("carry xor-bit result wrong");
  AST_STC_WRITE: assert property (seq_go(OP_STC) |=> ##3
    (mem_wr && mem_wdata[s.b2[MB_HI:MB_LO]] == s.psw[PSW_C]))
    else $error("carry not stored into memory bit");
  AST_TCLR_WRITE: assert property (seq_go(OP_TCLR) |=> ##3
    (mem_wr && mem_wdata == (s.mdat & ~s.acc)))
    else $error("test and mask-off wrote wrong value");
  AST_FBR_TAKEN: assert property ((start && dec.cls == CL_FBR && alu_taken) |=>
    seq_run4 ##1 (s.st == ST_IDLE))
    else $error("taken flag branch not four cycles");
  AST_FBR_SKIP: assert property ((s.cnt == CNT_CAP && fin && dec.cls == CL_FBR) |=>
    (s.st == ST_IDLE && s.pc == $past(s.pc) + 16'h0002))
    else $error("untaken flag branch wrong");
  AST_BRA_TARGET: assert property (seq_go(OP_BRA) |=> seq_run4 ##1
    (s.pc == $past(bra_tgt, 5)))
    else $error("relative jump target wrong");
endmodule : bbd_core

// >>> testbench/bbd_mem_model.sv
// bbd_mem_model: byte-wide data memory at the far side of the core.
// assumes the core samples read data one cycle after its read pulse.
`timescale 1ns/100ps
module bbd_mem_model
(
  // clock
  input  wire logic        core_clk,
  // memory port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] m [0:65535];
  initial mem_rdata = 8'h00;
  // data toggles outside a read, so a sample one cycle late looks wrong
  always @(posedge core_clk)
  begin
    if (mem_wr)
      m[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? m[mem_addr] : ~mem_rdata;
  end
endmodule : bbd_mem_model

// >>> testbench/tb.sv
// tb: runs single instructions through the axi4-lite registers.
// assumes the memory model answers the core's data port.
`timescale 1ns/100ps
module tb
  import bbd_pkg::*;
();
  logic core_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, mem_rd, mem_wr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mem_wdata, mem_rdata, bop [8], p;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] mem_addr;
  int bad_count, compares, fb [8];
  bbd_core dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_addr, .mem_rd,
    .mem_wr, .mem_wdata, .mem_rdata);
  bbd_mem_model mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic hang;
    bad_count++;
    $display("mismatch at %0t: no answer", $time);
    tally_and_finish;
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (s_axi_bvalid === 1'b1)
      begin
        rs = s_axi_bresp;
        return;
      end
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    hang;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (s_axi_rvalid === 1'b1)
      begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        return;
      end
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    hang;
  endtask : rd
  // one instruction from pc 1000, then cycles, acc, psw and pc compared
  task automatic run(input logic [23:0] i, input logic [7:0] a, input logic [7:0] ps,
    input logic [2:0] c, input logic [7:0] ea, input logic [7:0] ep, input logic [15:0] epc);
    wr(REG_INSN, {8'h00, i}, r);
    wr(REG_ACC, {24'h0, a}, r);
    wr(REG_PSW, {24'h0, ps}, r);
    wr(REG_PC, 32'h1000, r);
    wr(REG_CTRL, 32'h2, r);
    wr(REG_CTRL, 32'h1, r);
    for (int n = 0; n < 20; n++)
    begin
      rd(REG_STAT, d, r);
      if (d[SB_BUSY] === 1'b0)
        break;
      if (n == 19)
        hang;
    end
    chk({31'h0, d[SB_DONE]}, 32'h1);
    chk({29'h0, d[SB_CYC_HI:SB_CYC_LO]}, {29'h0, c});
    rd(REG_ACC, d, r);
    chk(d, {24'h0, ea});
    rd(REG_PSW, d, r);
    chk(d, {24'h0, ep});
    rd(REG_PC, d, r);
    chk(d, {16'h0, epc});
  endtask : run
  initial
  begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    compares = 0;
    bop = '{8'h50, 8'hd0, 8'hf0, 8'h70, 8'h90, 8'h10, 8'h30, 8'hb0};
    fb = '{PSW_C, PSW_C, PSW_Z, PSW_Z, PSW_N, PSW_N, PSW_V, PSW_V};
    mem.m[16'h0123] = 8'h08;
    mem.m[16'h0040] = 8'hc0;
    mem.m[16'h0200] = 8'h3c;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (bop[k])
    begin
      rd(8'h04 + 8'(k) * 8'h04, d, r);
      chk(d, (k < 5) ? 32'h0 : 32'hx);
      if (k == 4)
        break;
    end
    wr(8'h18, 32'h1, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    rd(8'h18, d, r);
    chk({d[29:0], r}, {30'h0, AXI_SLVERR});
    // opcode 00 is outside both groups: only the illegal flag rises
    wr(REG_INSN, 32'h0, r);
    wr(REG_CTRL, 32'h1, r);
    rd(REG_STAT, d, r);
    chk(d, 32'h4);
    run(24'h61238b, 8'h00, 8'hf1, 3'h4, 8'h00, 8'hf1, 16'h1003);
    run(24'h71238b, 8'h00, 8'h01, 3'h4, 8'h00, 8'h00, 16'h1003);
    run(24'h6123ab, 8'h00, 8'h01, 3'h5, 8'h00, 8'h00, 16'h1003);
    run(24'h7123ab, 8'h00, 8'h01, 3'h5, 8'h00, 8'h01, 16'h1003);
    run(24'h61236b, 8'h00, 8'h00, 3'h5, 8'h00, 8'h01, 16'h1003);
    run(24'h71236b, 8'h00, 8'h00, 3'h5, 8'h00, 8'h00, 16'h1003);
    run(24'h6123cb, 8'h00, 8'h00, 3'h4, 8'h00, 8'h01, 16'h1003);
    run(24'h7123cb, 8'h00, 8'h01, 3'h4, 8'h00, 8'h00, 16'h1003);
    run(24'h00400c, 8'h0f, 8'h00, 3'h4, 8'h0f, 8'hc2, 16'h1002);
    run(24'h01231c, 8'h08, 8'hc2, 3'h5, 8'h08, 8'h00, 16'h1003);
    run(24'h0040a1, 8'h00, 8'h5d, 3'h4, 8'h00, 8'h5d, 16'h1002);
    chk({24'h0, mem.m[16'h0040]}, 32'he0);
    run(24'h0040f1, 8'h00, 8'h5d, 3'h4, 8'h00, 8'h5d, 16'h1002);
    chk({24'h0, mem.m[16'h0040]}, 32'h60);
    run(24'h00022b, 8'hff, 8'h00, 3'h2, 8'hfb, 8'h00, 16'h1002);
    run(24'h00000b, 8'h00, 8'h00, 3'h2, 8'h01, 8'h00, 16'h1002);
    run(24'h000020, 8'h00, 8'hff, 3'h2, 8'h00, 8'hfe, 16'h1001);
    run(24'h000040, 8'h00, 8'hff, 3'h2, 8'h00, 8'hdf, 16'h1001);
    run(24'h000080, 8'h00, 8'hff, 3'h2, 8'h00, 8'hbf, 16'h1001);
    run(24'h0000a0, 8'h00, 8'h00, 3'h2, 8'h00, 8'h01, 16'h1001);
    run(24'h0000c0, 8'h00, 8'h00, 3'h2, 8'h00, 8'h20, 16'h1001);
    run(24'h6123eb, 8'h00, 8'h00, 3'h6, 8'h00, 8'h00, 16'h1003);
    chk({24'h0, mem.m[16'h0123]}, 32'h00);
    run(24'h61234b, 8'h00, 8'h5a, 3'h5, 8'h00, 8'h5a, 16'h1003);
    chk({24'h0, mem.m[16'h0123]}, 32'h08);
    run(24'h02005c, 8'h0c, 8'h00, 3'h6, 8'h0c, 8'h80, 16'h1003);
    chk({24'h0, mem.m[16'h0200]}, 32'h30);
    run(24'h02003c, 8'h41, 8'h82, 3'h6, 8'h41, 8'h00, 16'h1003);
    chk({24'h0, mem.m[16'h0200]}, 32'h71);
    run(24'h0004c2, 8'h40, 8'h00, 3'h6, 8'h40, 8'h00, 16'h1006);
    run(24'h0004d2, 8'h40, 8'h00, 3'h4, 8'h40, 8'h00, 16'h1002);
    run(24'hfd40e3, 8'h00, 8'h00, 3'h5, 8'h00, 8'h00, 16'h1003);
    run(24'hfd40f3, 8'h00, 8'h00, 3'h7, 8'h00, 8'h00, 16'h1000);
    run(24'h00802f, 8'h00, 8'h00, 3'h4, 8'h00, 8'h00, 16'h0f82);
    // each flag branch with its flag low and high; bit k of 96 is the taking level
    foreach (bop[k])
      for (int f = 0; f < 2; f++)
      begin
        logic tk;
        p = 8'(f) << fb[k];
        tk = (f == ((8'h96 >> k) & 1));
        run({16'h0010, bop[k]}, 8'h00, p, tk ? 3'h4 : 3'h2, 8'h00, p, tk ?
          16'h1012 : 16'h1002);
      end
    tally_and_finish;
  end
endmodule : tb
